// ===== logic/test_irq_pkg.sv
// Register map, field layout and reset values of the test and interrupt control registers.
package test_irq_pkg;

    // ------------------------------------------------------------
    // Register offsets on the microprocessor port
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_GLOBAL_GATE = 8'h06;
    localparam logic [7:0] ADDR_STATUS = 8'h07;
    localparam logic [7:0] ADDR_MASK = 8'h08;
    localparam logic [7:0] ADDR_TEST_COMMAND = 8'h09;

    // ------------------------------------------------------------
    // Status and mask bit positions
    // ------------------------------------------------------------
    localparam int BIT_FRAME_SYNC = 6;
    localparam int BIT_PATTERN_FOUND = 5;
    localparam int BIT_PATTERN_ERROR = 3;
    localparam int BIT_SELFTEST_DONE = 1;
    localparam int BIT_INSERT_DONE = 0;
    localparam int BIT_GLOBAL_GATE = 0;

    localparam logic [7:0] MASK_RESET = 8'h7F;
    localparam logic [7:0] MASK_RESERVED_ONES = 8'h14;
    localparam logic [7:0] MASK_WRITABLE = 8'h6B;
    localparam logic [7:0] STATUS_USED = 8'h6B;

    // ------------------------------------------------------------
    // Test command layout
    // ------------------------------------------------------------
    localparam int CMD_GEN_RUN = 7;
    localparam int CMD_CHK_RUN = 6;
    localparam int CMD_GEN_RATE_LSB = 4;
    localparam int CMD_CHK_RATE_LSB = 2;
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] CMD_WRITABLE = 8'hFC;

    typedef enum logic [1:0] {
        RATE_2048K = 2'b00,
        RATE_4096K = 2'b01,
        RATE_8192K = 2'b10,
        RATE_IDLE = 2'b11
    } rate_type;

    // ------------------------------------------------------------
    // Checker lock
    // ------------------------------------------------------------
    localparam int LOCK_SLOTS = 32;
    localparam int LOCK_WIDTH = 6;

    typedef enum logic [1:0] {
        CHK_OFF = 2'b00,
        CHK_HUNT = 2'b01,
        CHK_LOCKED = 2'b10
    } checker_state_type;

endpackage : test_irq_pkg

// ===== logic/pattern_lock_monitor.sv
// Checker lock tracking: hunts for error-free slots and reports lock and later errors.
`timescale 1ns/100ps
`default_nettype none
module pattern_lock_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic slotValid,
    input wire logic slotError,
    output logic foundPulse,
    output logic errorPulse,
    output logic locked
);

    test_irq_pkg::checker_state_type state;
    logic [test_irq_pkg::LOCK_WIDTH-1:0] goodCount;

    // ------------------------------------------------------------
    // Lock state machine
    // ------------------------------------------------------------
    // An error while hunting restarts the run; lock needs an unbroken run.
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            state <= test_irq_pkg::CHK_OFF;
            goodCount <= '0;
        end else begin
            case (state)
                test_irq_pkg::CHK_OFF: begin
                    state <= test_irq_pkg::CHK_HUNT;
                    goodCount <= '0;
                end
                test_irq_pkg::CHK_HUNT: begin
                    if (slotValid && slotError) begin
                        goodCount <= '0;
                    end else if (slotValid) begin
                        if (goodCount == test_irq_pkg::LOCK_WIDTH'(test_irq_pkg::LOCK_SLOTS - 1)) begin
                            state <= test_irq_pkg::CHK_LOCKED;
                        end
                        goodCount <= goodCount + 1'b1;
                    end
                end
                test_irq_pkg::CHK_LOCKED: begin
                    state <= test_irq_pkg::CHK_LOCKED;
                end
                default: begin
                    state <= test_irq_pkg::CHK_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            foundPulse <= 1'b0;
            errorPulse <= 1'b0;
        end else begin
            foundPulse <= enable && state == test_irq_pkg::CHK_HUNT && slotValid && !slotError
                && goodCount == test_irq_pkg::LOCK_WIDTH'(test_irq_pkg::LOCK_SLOTS - 1);
            errorPulse <= enable && state == test_irq_pkg::CHK_LOCKED && slotValid && slotError;
        end
    end

    assign locked = (state == test_irq_pkg::CHK_LOCKED);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_lock_needs_run: assert property (foundPulse |-> $past(goodCount) == 6'h1F)
        else $error("Lock reported without a full error-free run.");
    a_lock_after_found: assert property (foundPulse && enable |-> locked)
        else $error("Lock state missing after found pulse.");

endmodule : pattern_lock_monitor
`default_nettype wire

// ===== logic/test_irq_control_regs.sv
// Interrupt mask, status, global gate and test command registers of the switch.
//
// Contract
// - Frame sync mask bit six blocks interrupt.
// - Frame sync mask also stops flag setting.
// - All functional mask bits reset to one.
// - Mask bit five blocks pattern found interrupt.
// - Mask bit three blocks pattern error interrupt.
// - Mask bit one blocks selftest done interrupt.
// - Mask bit zero blocks insertion done interrupt.
// - Reserved mask bits four, two read one.
// - Command bit seven one starts generator.
// - Command bit seven zero halts generator.
// - Command bit six one starts checker.
// - Command bit six zero halts checker.
// - Generator rate field codes, eleven idle.
// - Checker rate field same codes, idle.
// - One transmit highway carries generated pattern.
// - One receive highway checked at once.
// - Testing leaves other switching untouched.
// - Interrupt needs gate and unmasked flag.
// - Status read clears flags until events.
// - Pattern found after 32 good slots.
`timescale 1ns/100ps
`default_nettype none
module test_irq_control_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] writeData,
    input wire logic writeStrobe,
    input wire logic readStrobe,
    output logic [7:0] readData,
    input wire logic frameSyncFault,
    input wire logic selftestDone,
    input wire logic errorInsertDone,
    input wire logic checkSlotValid,
    input wire logic checkSlotError,
    output logic generatorRun,
    output logic checkerRun,
    output logic [1:0] generatorRateSel,
    output logic [1:0] checkerRateSel,
    output logic generatorActive,
    output logic checkerActive,
    output logic checkerLocked,
    output logic irq
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] irqSourceMask;
    logic [7:0] testCommand;
    logic [7:0] statusFlags;
    logic globalIrqGate;
    logic foundPulse;
    logic errorPulse;
    logic statusRead;
    logic [7:0] statusEvents;
    logic [7:0] next_statusFlags;
    logic [7:0] pending;
    logic maskWrite;
    logic commandWrite;
    logic gateWrite;
    logic [test_irq_pkg::LOCK_WIDTH-1:0] cleanRun;

    // A rate code of all ones means the engine neither sends nor receives.
    function automatic logic rateMoves(input logic [1:0] rate);
        rateMoves = (rate != test_irq_pkg::RATE_IDLE);
    endfunction : rateMoves

    // A bus cycle hits a register when its strobe and address agree.
    function automatic logic regHit(input logic strobe, input logic [7:0] regAddr,
        input logic [7:0] target);
        regHit = strobe && (regAddr == target);
    endfunction : regHit

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign maskWrite = regHit(writeStrobe, addr, test_irq_pkg::ADDR_MASK);
    assign commandWrite = regHit(writeStrobe, addr, test_irq_pkg::ADDR_TEST_COMMAND);
    assign gateWrite = regHit(writeStrobe, addr, test_irq_pkg::ADDR_GLOBAL_GATE);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            irqSourceMask <= test_irq_pkg::MASK_RESET;
        end else if (maskWrite) begin
            // Reserved positions are forced so a careless write cannot clear them.
            irqSourceMask <= (writeData & test_irq_pkg::MASK_WRITABLE)
                | test_irq_pkg::MASK_RESERVED_ONES;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            testCommand <= test_irq_pkg::CMD_RESET;
        end else if (commandWrite) begin
            testCommand <= writeData & test_irq_pkg::CMD_WRITABLE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            globalIrqGate <= 1'b0;
        end else if (gateWrite) begin
            globalIrqGate <= writeData[test_irq_pkg::BIT_GLOBAL_GATE];
        end
    end

    // ------------------------------------------------------------
    // Test engine controls
    // ------------------------------------------------------------
    assign generatorRun = testCommand[test_irq_pkg::CMD_GEN_RUN];
    assign checkerRun = testCommand[test_irq_pkg::CMD_CHK_RUN];
    assign generatorRateSel = testCommand[test_irq_pkg::CMD_GEN_RATE_LSB +: 2];
    assign checkerRateSel = testCommand[test_irq_pkg::CMD_CHK_RATE_LSB +: 2];

    // Each engine serves exactly one highway slot stream, chosen elsewhere;
    // these enables touch only that engine, never the switch path itself.
    assign generatorActive = generatorRun && rateMoves(generatorRateSel);
    assign checkerActive = checkerRun && rateMoves(checkerRateSel);

    pattern_lock_monitor lockMonitor (
        .clk(clk),
        .rst(rst),
        .enable(checkerActive),
        .slotValid(checkSlotValid),
        .slotError(checkSlotError),
        .foundPulse(foundPulse),
        .errorPulse(errorPulse),
        .locked(checkerLocked)
    );

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    assign statusRead = regHit(readStrobe, addr, test_irq_pkg::ADDR_STATUS);

    always_comb begin
        statusEvents = 8'h00;
        // Frame sync faults are not even recorded while masked, which keeps
        // the first frame pulse after reset from leaving a stale flag.
        statusEvents[test_irq_pkg::BIT_FRAME_SYNC] = frameSyncFault
            && !irqSourceMask[test_irq_pkg::BIT_FRAME_SYNC];
        statusEvents[test_irq_pkg::BIT_PATTERN_FOUND] = foundPulse;
        statusEvents[test_irq_pkg::BIT_PATTERN_ERROR] = errorPulse;
        statusEvents[test_irq_pkg::BIT_SELFTEST_DONE] = selftestDone;
        statusEvents[test_irq_pkg::BIT_INSERT_DONE] = errorInsertDone;
    end

    // A read clears the flags, but an event in the same cycle still lands.
    assign next_statusFlags = ((statusRead ? 8'h00 : statusFlags) | statusEvents)
        & test_irq_pkg::STATUS_USED;

    always_ff @(posedge clk) begin
        if (rst) begin
            statusFlags <= 8'h00;
        end else begin
            statusFlags <= next_statusFlags;
        end
    end

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    assign pending = statusFlags & ~irqSourceMask & test_irq_pkg::STATUS_USED;

    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= globalIrqGate && (|pending);
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            readData <= 8'h00;
        end else if (readStrobe) begin
            if (addr == test_irq_pkg::ADDR_GLOBAL_GATE) begin
                readData <= {7'h00, globalIrqGate};
            end else if (addr == test_irq_pkg::ADDR_STATUS) begin
                readData <= statusFlags;
            end else if (addr == test_irq_pkg::ADDR_MASK) begin
                readData <= irqSourceMask;
            end else if (addr == test_irq_pkg::ADDR_TEST_COMMAND) begin
                readData <= testCommand;
            end else begin
                readData <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Independent count of clean slots, so the lock check does not lean on
    // the monitor's own counter.
    always_ff @(posedge clk) begin
        if (rst || !checkerActive || checkerLocked) begin
            cleanRun <= '0;
        end else if (checkSlotValid && checkSlotError) begin
            cleanRun <= '0;
        end else if (checkSlotValid && cleanRun != '1) begin
            cleanRun <= cleanRun + 1'b1;
        end
    end

    a_fse_no_set: assert property (
        irqSourceMask[6] && !statusFlags[6] && !statusRead |=> !statusFlags[6])
        else $error("Frame sync flag set while its mask was one.");

    a_fse_no_irq: assert property (
        irqSourceMask[6] && (statusFlags & ~irqSourceMask & 8'h6B) == 8'h00 |=> !irq)
        else $error("Interrupt raised by a masked source.");

    a_mask_reset_value: assert property (
        $fell(rst) |-> irqSourceMask == 8'h7F)
        else $error("Mask register left reset with a wrong value.");

    a_mask_rsvd_ones: assert property (
        irqSourceMask[4] && irqSourceMask[2] && !irqSourceMask[7])
        else $error("Reserved mask bits hold a wrong value.");

    a_found_masked: assert property (
        irqSourceMask[5] && statusFlags == 8'h20 |=> !irq)
        else $error("Pattern found raised a masked interrupt.");

    a_error_masked: assert property (
        irqSourceMask[3] && statusFlags == 8'h08 |=> !irq)
        else $error("Pattern error raised a masked interrupt.");

    a_selftest_masked: assert property (
        irqSourceMask[1] && statusFlags == 8'h02 |=> !irq)
        else $error("Selftest done raised a masked interrupt.");

    a_insert_masked: assert property (
        irqSourceMask[0] && statusFlags == 8'h01 |=> !irq)
        else $error("Insertion done raised a masked interrupt.");

    a_gen_run_write: assert property (
        commandWrite |=> generatorRun == $past(writeData[7]))
        else $error("Generator run does not follow the command write.");

    a_chk_run_write: assert property (
        commandWrite |=> checkerRun == $past(writeData[6]))
        else $error("Checker run does not follow the command write.");

    a_idle_rate_off: assert property (
        generatorRateSel == 2'b11 |-> !generatorActive)
        else $error("Generator active at the idle rate.");

    a_chk_idle_off: assert property (
        checkerRateSel == 2'b11 |-> !checkerActive)
        else $error("Checker active at the idle rate.");

    a_irq_needs_gate: assert property (
        irq |-> $past(globalIrqGate) && $past(|pending))
        else $error("Interrupt raised without gate or pending flag.");

    a_read_clears: assert property (
        statusRead && statusEvents == 8'h00 |=> statusFlags == 8'h00)
        else $error("Status read did not clear the flags.");

    a_set_beats_clear: assert property (
        statusRead && selftestDone |=> statusFlags[1])
        else $error("Event lost in the cycle of a status read.");

    a_mask_write_lands: assert property (
        maskWrite |=> irqSourceMask == (($past(writeData) & 8'h6B) | 8'h14))
        else $error("Mask write stored a wrong value.");

    a_gen_rate_write: assert property (
        commandWrite |=> generatorRateSel == $past(writeData[5:4]))
        else $error("Generator rate does not follow the command write.");

    a_chk_rate_write: assert property (
        commandWrite |=> checkerRateSel == $past(writeData[3:2]))
        else $error("Checker rate does not follow the command write.");

    a_cmd_reset_value: assert property (
        $fell(rst) |-> testCommand == 8'h00)
        else $error("Command register left reset with a wrong value.");

    a_gate_write: assert property (
        gateWrite |=> globalIrqGate == $past(writeData[0]))
        else $error("Gate does not follow its write.");

    a_gate_off_quiet: assert property (
        !globalIrqGate |=> !irq)
        else $error("Interrupt raised while the gate was off.");

    a_irq_follows: assert property (
        globalIrqGate && (|pending) |=> irq)
        else $error("Pending unmasked flag did not raise the interrupt.");

    a_irq_lag_two: assert property (
        selftestDone && !irqSourceMask[1] && globalIrqGate && !writeStrobe |=> ##1 irq)
        else $error("Interrupt missing two cycles after an unmasked event.");

    a_read_data_status: assert property (
        statusRead |=> readData == $past(statusFlags))
        else $error("Status read returned a wrong value.");

    a_flags_hold: assert property (
        !statusRead |=> (statusFlags & $past(statusFlags)) == $past(statusFlags))
        else $error("Status flag dropped without a read.");

    a_clear_stays: assert property (
        statusFlags == 8'h00 && statusEvents == 8'h00 |=> statusFlags == 8'h00)
        else $error("Status flag set without an event.");

    a_events_land: assert property (
        |statusEvents |=> (statusFlags & $past(statusEvents)) == $past(statusEvents))
        else $error("Status event not recorded.");

    a_fse_sets_open: assert property (
        frameSyncFault && !irqSourceMask[6] |=> statusFlags[6])
        else $error("Unmasked frame sync fault not recorded.");

    a_found_sets_flag: assert property (
        foundPulse |=> statusFlags[5])
        else $error("Pattern found flag not set after lock.");

    a_lock_run_count: assert property (
        foundPulse |-> cleanRun >= 6'h20)
        else $error("Lock reported before enough clean slots.");

    a_status_rsvd_zero: assert property (
        (statusFlags & 8'h94) == 8'h00)
        else $error("Reserved status bits not zero.");

    c_irq_raised: cover property (globalIrqGate && !irq ##1 irq);
    c_pattern_found: cover property (foundPulse);
    c_status_read: cover property (statusRead && statusFlags != 8'h00);
    c_both_running: cover property (generatorActive && checkerActive);
    c_fse_dropped: cover property (frameSyncFault && irqSourceMask[6]);

endmodule : test_irq_control_regs
`default_nettype wire

// ===== verification/test_irq_control_regs_tb.sv
// Self-checking bench for the interrupt mask, status, gate and test command registers.
`timescale 1ns/100ps
`default_nettype none
module test_irq_control_regs_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] writeData = 8'h00;
    logic writeStrobe = 1'b0;
    logic readStrobe = 1'b0;
    logic frameSyncFault = 1'b0;
    logic selftestDone = 1'b0;
    logic errorInsertDone = 1'b0;
    logic checkSlotValid = 1'b0;
    logic checkSlotError = 1'b0;
    logic [7:0] readData;
    logic generatorRun, checkerRun, generatorActive, checkerActive, checkerLocked, irq;
    logic [1:0] generatorRateSel, checkerRateSel;
    integer errTotal = 0, checkCount = 0, seed = 49299;
    integer modelMask = 8'h7F, modelCmd = 8'h00, modelGate = 8'h00, modelStatus = 8'h00;
    logic [7:0] v;
    int srcs[3] = '{6, 1, 0};

    always #5 clk = ~clk;

    test_irq_control_regs dut_u (
        .clk(clk), .rst(rst), .addr(addr), .writeData(writeData),
        .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
        .frameSyncFault(frameSyncFault), .selftestDone(selftestDone),
        .errorInsertDone(errorInsertDone), .checkSlotValid(checkSlotValid),
        .checkSlotError(checkSlotError), .generatorRun(generatorRun), .checkerRun(checkerRun),
        .generatorRateSel(generatorRateSel), .checkerRateSel(checkerRateSel),
        .generatorActive(generatorActive), .checkerActive(checkerActive),
        .checkerLocked(checkerLocked), .irq(irq)
    );

    // ------------------------------------------------------------
    // Bus cycles, reference model and comparison
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            errTotal++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        writeData = d;
        writeStrobe = 1'b1;
        @(negedge clk);
        writeStrobe = 1'b0;
        if (a == test_irq_pkg::ADDR_MASK) modelMask = (d & 8'h6B) | 8'h14;
        if (a == test_irq_pkg::ADDR_TEST_COMMAND) modelCmd = d & 8'hFC;
        if (a == test_irq_pkg::ADDR_GLOBAL_GATE) modelGate = d & 8'h01;
    endtask : wr

    task automatic rdReg(input logic [7:0] a);
        logic [7:0] exp;
        exp = 8'h00;
        if (a == test_irq_pkg::ADDR_MASK) exp = modelMask[7:0];
        if (a == test_irq_pkg::ADDR_TEST_COMMAND) exp = modelCmd[7:0];
        if (a == test_irq_pkg::ADDR_GLOBAL_GATE) exp = modelGate[7:0];
        if (a == test_irq_pkg::ADDR_STATUS) exp = modelStatus[7:0];
        @(negedge clk);
        addr = a;
        readStrobe = 1'b1;
        @(negedge clk);
        readStrobe = 1'b0;
        if (a == test_irq_pkg::ADDR_STATUS) modelStatus = 0;
        check(readData, exp);
    endtask : rdReg

    function automatic logic expIrq();
        return (modelGate[0] == 1'b1) && ((modelStatus & ~modelMask & 8'h6B) != 0);
    endfunction : expIrq

    // The frame sync source is dropped at the input while its mask bit is set.
    task automatic pulse(input int s);
        @(negedge clk);
        frameSyncFault = (s == 6);
        selftestDone = (s == 1);
        errorInsertDone = (s == 0);
        @(negedge clk);
        {frameSyncFault, selftestDone, errorInsertDone} = 3'b000;
        if (!(s == 6 && modelMask[6])) modelStatus = modelStatus | (1 << s);
        repeat (2) @(negedge clk);
    endtask : pulse

    task automatic slots(input int n, input logic e);
        repeat (n) begin
            @(negedge clk);
            checkSlotValid = 1'b1;
            checkSlotError = e;
        end
        @(negedge clk);
        checkSlotValid = 1'b0;
        checkSlotError = 1'b0;
    endtask : slots

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (50000) @(posedge clk);
        errTotal++;
        $display("FAIL at %0t: timeout got %h expected %h", $time, 8'h00, 8'h01);
        tally_and_finish();
    end

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rdReg(test_irq_pkg::ADDR_MASK);
        rdReg(test_irq_pkg::ADDR_TEST_COMMAND);
        rdReg(test_irq_pkg::ADDR_STATUS);
        rdReg(test_irq_pkg::ADDR_GLOBAL_GATE);
        rdReg(8'h20);
        check({generatorRun, checkerRun, generatorRateSel, checkerRateSel}, 8'h00);
        repeat (6) begin
            v = 8'($random(seed));
            wr(test_irq_pkg::ADDR_MASK, v | 8'h14);
            rdReg(test_irq_pkg::ADDR_MASK);
        end
        for (int i = 0; i < 16; i++) begin
            v = 8'(($random(seed) & 8'hC3) | (i[1:0] << 4) | (i[3:2] << 2));
            wr(test_irq_pkg::ADDR_TEST_COMMAND, v);
            check({generatorRun, generatorRateSel}, {v[7], v[5:4]});
            check({checkerRun, checkerRateSel}, {v[6], v[3:2]});
            check(generatorActive, v[7] && v[5:4] != 2'b11);
            check(checkerActive, v[6] && v[3:2] != 2'b11);
            rdReg(test_irq_pkg::ADDR_TEST_COMMAND);
        end
        wr(test_irq_pkg::ADDR_TEST_COMMAND, 8'h00);
        check({generatorActive, checkerActive}, 8'h00);
        wr(8'h0A, 8'hFF);
        rdReg(test_irq_pkg::ADDR_TEST_COMMAND);
        wr(test_irq_pkg::ADDR_GLOBAL_GATE, 8'hFF);
        foreach (srcs[k]) begin
            wr(test_irq_pkg::ADDR_MASK, 8'h14 | (1 << srcs[k]));
            pulse(srcs[k]);
            check(irq, expIrq());
            rdReg(test_irq_pkg::ADDR_STATUS);
            wr(test_irq_pkg::ADDR_MASK, 8'h14);
            pulse(srcs[k]);
            check(irq, expIrq());
            rdReg(test_irq_pkg::ADDR_STATUS);
            repeat (2) @(negedge clk);
            check(irq, expIrq());
        end
        wr(test_irq_pkg::ADDR_GLOBAL_GATE, 8'h00);
        pulse(1);
        check(irq, expIrq());
        wr(test_irq_pkg::ADDR_GLOBAL_GATE, 8'h01);
        repeat (2) @(negedge clk);
        check(irq, expIrq());
        rdReg(test_irq_pkg::ADDR_STATUS);
        wr(test_irq_pkg::ADDR_TEST_COMMAND, 8'h40);
        repeat (2) @(negedge clk);
        slots(31, 1'b0);
        slots(1, 1'b1);
        slots(31, 1'b0);
        check(checkerLocked, 1'b0);
        rdReg(test_irq_pkg::ADDR_STATUS);
        slots(1, 1'b0);
        repeat (3) @(negedge clk);
        modelStatus = modelStatus | 8'h20;
        check(checkerLocked, 1'b1);
        check(irq, expIrq());
        wr(test_irq_pkg::ADDR_MASK, 8'h34);
        repeat (2) @(negedge clk);
        check(irq, expIrq());
        wr(test_irq_pkg::ADDR_MASK, 8'h14);
        rdReg(test_irq_pkg::ADDR_STATUS);
        slots(1, 1'b1);
        repeat (3) @(negedge clk);
        modelStatus = modelStatus | 8'h08;
        check(irq, expIrq());
        wr(test_irq_pkg::ADDR_MASK, 8'h1C);
        repeat (2) @(negedge clk);
        check(irq, expIrq());
        wr(test_irq_pkg::ADDR_MASK, 8'h14);
        rdReg(test_irq_pkg::ADDR_STATUS);
        wr(test_irq_pkg::ADDR_TEST_COMMAND, 8'h4C);
        repeat (2) @(negedge clk);
        check({checkerActive, checkerLocked}, 8'h00);
        tally_and_finish();
    end
endmodule : test_irq_control_regs_tb
`default_nettype wire
